// *** i2csf_top.v ***
// Two-wire bus status-flag logic with AXI4-Lite register slave
`timescale 1ns/1ps
`include "i2csf_consts.vh"
// Functional notes
// - Byte-done low while shifting the address byte, set at ninth fall
// - Slave match set on own address call
// - Control write clears slave match
// - Busy set on START, cleared on STOP
// - Arb lost: SDA low while driving high
// - Arb lost: receive acknowledge driven high, low
// - Arb lost: start requested while bus busy
// - Arb lost: repeated start in slave mode
// - Arb lost: unrequested STOP detected
// - Arb lost held until software writes zero
// - Direction flag shows calling read/write bit
// - Irq pending on byte, match of a write call, arb lost
// - Irq pending held until software writes zero
// - Interrupt when pending and enable set
// - Receive ack flag captures ninth-bit SDA
// - Arb lost clears master select, no STOP
// - Data access in direction clears byte-done
module i2csf_top (
    input wire CLOCK,
    input wire RSTN,
    input wire SCL_IN,
    input wire SDA_IN,
    output reg SDA_OUT,
    output reg SDA_OE,
    output reg SCL_OUT,
    output reg SCL_OE,
    input wire [11:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output reg S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output reg S_AXI_WREADY,
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [11:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output reg S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY,
    output reg IRQ,
    output reg EV_IRQ
);
    // Bus line synchronisers and edge detect
    reg scl_s1_reg, scl_s2_reg, scl_d_reg;
    reg sda_s1_reg, sda_s2_reg, sda_d_reg;
    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            scl_d_reg <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_s1_reg <= SCL_IN;
            scl_s2_reg <= scl_s1_reg;
            scl_d_reg <= scl_s2_reg;
            sda_s1_reg <= SDA_IN;
            sda_s2_reg <= sda_s1_reg;
            sda_d_reg <= sda_s2_reg;
        end
    end
    wire scl_rise = scl_s2_reg & ~scl_d_reg;
    wire scl_fall = ~scl_s2_reg & scl_d_reg;
    wire start_det = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
    wire stop_det = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

    // Registers
    reg [7:0] ctrl_reg;
    reg [7:0] own_addr_reg;
    reg [7:0] data_reg;
    reg done_reg;
    reg match_reg;
    reg busy_reg;
    reg arb_reg;
    reg dir_reg;
    reg irqp_reg;
    reg rxack_reg;
    localparam [7:0] status_rst = `I2CSF_STATUS_RST;
    reg [3:0] ev_st_reg;
    reg [3:0] ev_en_reg;
    // Byte tracking on the bus
    reg [3:0] bit_cnt_reg;
    reg [7:0] shift_reg;
    reg addr_phase_reg;
    reg slave_act_reg;
    reg stop_req_reg;
    reg drive_hi_reg;

    // AXI write channel capture
    reg aw_have_reg, w_have_reg;
    reg [11:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    wire wr_fire = aw_have_reg & w_have_reg & ~S_AXI_BVALID;
    wire wr_lane0 = wr_fire & w_strb_reg[0];
    wire wr_ctrl = wr_lane0 && aw_addr_reg == `I2CSF_OFF_CTRL;
    wire wr_stat = wr_lane0 && aw_addr_reg == `I2CSF_OFF_STATUS;
    wire wr_data = wr_lane0 && aw_addr_reg == `I2CSF_OFF_DATA;
    wire wr_own = wr_lane0 && aw_addr_reg == `I2CSF_OFF_OWNADDR;
    wire wr_ien = wr_lane0 && aw_addr_reg == `I2CSF_OFF_IRQ_EN;
    wire wr_iclr = wr_lane0 && aw_addr_reg == `I2CSF_OFF_IRQ_CLR;
    wire rd_take = S_AXI_ARVALID & S_AXI_ARREADY;
    wire rd_data = rd_take && S_AXI_ARADDR == `I2CSF_OFF_DATA;

    function is_mapped;
        input [11:0] a;
        begin
            is_mapped = (a == `I2CSF_OFF_CTRL) || (a == `I2CSF_OFF_STATUS) ||
                (a == `I2CSF_OFF_DATA) || (a == `I2CSF_OFF_OWNADDR) ||
                (a == `I2CSF_OFF_IRQ_ST) || (a == `I2CSF_OFF_IRQ_EN) ||
                (a == `I2CSF_OFF_IRQ_CLR);
        end
    endfunction

    wire enabled = ctrl_reg[`I2CSF_C_EN];
    wire master = ctrl_reg[`I2CSF_C_MSEL];
    wire tx_mode = ctrl_reg[`I2CSF_C_TX];
    // Control write intents
    wire start_req = wr_ctrl & enabled & w_data_reg[`I2CSF_C_MSEL] & ~master;
    wire rstart_req = wr_ctrl & enabled & w_data_reg[`I2CSF_C_RSTART];
    wire stop_ask = wr_ctrl & master & ~w_data_reg[`I2CSF_C_MSEL];

    // Ninth-bit fall and bit sampling
    wire ninth_fall = scl_fall & (bit_cnt_reg == 4'h9);
    // Acknowledge bit kept out of the shifted byte
    wire sample = scl_rise & (bit_cnt_reg < 4'h8);
    wire ack_bit = bit_cnt_reg == 4'h8;
    wire addr_byte_done = scl_rise & (bit_cnt_reg == 4'h7) & addr_phase_reg;
    wire [7:0] call = {shift_reg[6:0], sda_s2_reg};
    wire own_call = addr_byte_done && call[7:1] == own_addr_reg[7:1] && !master;
    // Arbitration loss sources
    wire arb_sda = master & drive_hi_reg & scl_rise & ~sda_s2_reg &
        (((addr_phase_reg | tx_mode) & ~ack_bit) | (~tx_mode & ack_bit));
    wire arb_start = start_req & busy_reg;
    wire arb_rs = rstart_req & ~master;
    wire arb_stop = stop_det & master & ~stop_req_reg;
    wire arb_ev = enabled & (arb_sda | arb_start | arb_rs | arb_stop);

    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            bit_cnt_reg <= 4'hF;
            shift_reg <= 8'h00;
            addr_phase_reg <= 1'b0;
            slave_act_reg <= 1'b0;
            stop_req_reg <= 1'b0;
            drive_hi_reg <= 1'b0;
        end else begin
            drive_hi_reg <= SDA_OE ? 1'b0 : (master & enabled);
            if (stop_ask)
                stop_req_reg <= 1'b1;
            else if (stop_det)
                stop_req_reg <= 1'b0;
            if (start_det) begin
                bit_cnt_reg <= 4'h0;
                addr_phase_reg <= 1'b1;
                slave_act_reg <= 1'b0;
            end else if (stop_det) begin
                bit_cnt_reg <= 4'hF;
                addr_phase_reg <= 1'b0;
                slave_act_reg <= 1'b0;
            end else begin
                if (sample)
                    shift_reg <= call;
                if (scl_rise && bit_cnt_reg < 4'h9)
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                if (ninth_fall) begin
                    bit_cnt_reg <= 4'h0;
                    addr_phase_reg <= 1'b0;
                end
                if (own_call)
                    slave_act_reg <= 1'b1;
            end
        end
    end

    // Status flags
    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            done_reg <= status_rst[`I2CSF_B_DONE];
        end else begin
            if (ninth_fall && enabled)
                done_reg <= 1'b1;
            else if ((scl_fall && bit_cnt_reg == 4'h0) || start_det)
                done_reg <= 1'b0;
            else if ((rd_data && !tx_mode) || (wr_data && tx_mode))
                done_reg <= 1'b0;
        end
    end

    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            match_reg <= 1'b0;
            dir_reg <= 1'b0;
        end else begin
            if (own_call && enabled) begin
                match_reg <= 1'b1;
                dir_reg <= call[0];
            end else if (wr_ctrl) begin
                match_reg <= 1'b0;
            end
        end
    end

    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            busy_reg <= 1'b0;
        end else begin
            if (start_det)
                busy_reg <= 1'b1;
            else if (stop_det)
                busy_reg <= 1'b0;
        end
    end

    // Set wins over a same-cycle software clear
    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            arb_reg <= 1'b0;
        end else begin
            if (arb_ev)
                arb_reg <= 1'b1;
            else if (wr_stat && !w_data_reg[`I2CSF_B_ARB])
                arb_reg <= 1'b0;
        end
    end

    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            irqp_reg <= 1'b0;
        end else begin
            if ((ninth_fall && enabled) || (own_call && enabled && !call[0]) || arb_ev)
                irqp_reg <= 1'b1;
            else if (wr_stat && !w_data_reg[`I2CSF_B_IRQP])
                irqp_reg <= 1'b0;
        end
    end

    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            rxack_reg <= status_rst[`I2CSF_B_RXACK];
        end else begin
            if (scl_rise && ack_bit)
                rxack_reg <= sda_s2_reg;
        end
    end

    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_reg <= `I2CSF_CTRL_RST;
        end else begin
            if (wr_ctrl)
                ctrl_reg <= {w_data_reg[7:3], 3'b000};
            if (arb_ev)
                ctrl_reg[`I2CSF_C_MSEL] <= 1'b0;
        end
    end

    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            own_addr_reg <= 8'h00;
            data_reg <= 8'h00;
        end else begin
            if (wr_own)
                own_addr_reg <= w_data_reg[7:0];
            if (wr_data)
                data_reg <= w_data_reg[7:0];
            else if (ninth_fall && !tx_mode)
                data_reg <= shift_reg;
        end
    end

    wire [7:0] status = {done_reg, match_reg, busy_reg, arb_reg, 1'b0, dir_reg,
        irqp_reg, rxack_reg};
    wire [3:0] ev_now = {ninth_fall & enabled, own_call & enabled, start_det, arb_ev};

    // Sticky event status, enable, write-one clear
    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ev_st_reg <= 4'h0;
            ev_en_reg <= 4'h0;
        end else begin
            ev_st_reg <= ev_now | (ev_st_reg & ~(wr_iclr ? w_data_reg[3:0] : 4'h0));
            if (wr_ien)
                ev_en_reg <= w_data_reg[3:0];
        end
    end

    // AXI4-Lite slave
    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `I2CSF_RESP_OKAY;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= `I2CSF_RESP_OKAY;
        end else begin
            S_AXI_AWREADY <= ~aw_have_reg & ~S_AXI_AWREADY & ~S_AXI_BVALID;
            S_AXI_WREADY <= ~w_have_reg & ~S_AXI_WREADY & ~S_AXI_BVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= {S_AXI_AWADDR[11:2], 2'b00};
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_have_reg <= 1'b1;
                w_data_reg <= S_AXI_WDATA;
                w_strb_reg <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= is_mapped(aw_addr_reg) ? `I2CSF_RESP_OKAY : `I2CSF_RESP_SLVERR;
            end else if (S_AXI_BREADY)
                S_AXI_BVALID <= 1'b0;
            S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & ~S_AXI_ARVALID ? 1'b0 :
                (~S_AXI_ARREADY & ~S_AXI_RVALID);
            if (rd_take) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= is_mapped({S_AXI_ARADDR[11:2], 2'b00}) ?
                    `I2CSF_RESP_OKAY : `I2CSF_RESP_SLVERR;
                case ({S_AXI_ARADDR[11:2], 2'b00})
                    `I2CSF_OFF_CTRL: S_AXI_RDATA <= {24'h000000, ctrl_reg};
                    `I2CSF_OFF_STATUS: S_AXI_RDATA <= {24'h000000, status};
                    `I2CSF_OFF_DATA: S_AXI_RDATA <= {24'h000000, data_reg};
                    `I2CSF_OFF_OWNADDR: S_AXI_RDATA <= {24'h000000, own_addr_reg};
                    `I2CSF_OFF_IRQ_ST: S_AXI_RDATA <= {28'h0000000, ev_st_reg};
                    `I2CSF_OFF_IRQ_EN: S_AXI_RDATA <= {28'h0000000, ev_en_reg};
                    default: S_AXI_RDATA <= 32'h00000000;
                endcase
            end else if (S_AXI_RREADY)
                S_AXI_RVALID <= 1'b0;
        end
    end

    // Outputs; the bus lines are only released here, the shifter is outside
    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            IRQ <= 1'b0;
            EV_IRQ <= 1'b0;
            SDA_OUT <= 1'b0;
            SDA_OE <= 1'b0;
            SCL_OUT <= 1'b0;
            SCL_OE <= 1'b0;
        end else begin
            IRQ <= irqp_reg & ctrl_reg[`I2CSF_C_IEN];
            EV_IRQ <= |(ev_st_reg & ev_en_reg);
            SDA_OUT <= 1'b0;
            SDA_OE <= 1'b0;
            SCL_OUT <= 1'b0;
            SCL_OE <= 1'b0;
        end
    end
endmodule // i2csf_top

// *** i2csf_consts.vh ***
// Register map, field positions and reset values of the status-flag block
`ifndef I2CSF_CONSTS_VH
`define I2CSF_CONSTS_VH
`define I2CSF_ADDR_W 12
`define I2CSF_OFF_CTRL 12'h288
`define I2CSF_OFF_STATUS 12'h28C
`define I2CSF_OFF_DATA 12'h290
`define I2CSF_OFF_OWNADDR 12'h284
`define I2CSF_OFF_IRQ_ST 12'h2A0
`define I2CSF_OFF_IRQ_EN 12'h2A4
`define I2CSF_OFF_IRQ_CLR 12'h2A8
`define I2CSF_STATUS_RST 8'h81
`define I2CSF_CTRL_RST 8'h00
`define I2CSF_B_DONE 7
`define I2CSF_B_MATCH 6
`define I2CSF_B_BUSY 5
`define I2CSF_B_ARB 4
`define I2CSF_B_DIR 2
`define I2CSF_B_IRQP 1
`define I2CSF_B_RXACK 0
`define I2CSF_C_EN 7
`define I2CSF_C_IEN 6
`define I2CSF_C_MSEL 5
`define I2CSF_C_TX 4
`define I2CSF_C_RSTART 2
`define I2CSF_EV_W 4
`define I2CSF_RESP_OKAY 2'h0
`define I2CSF_RESP_SLVERR 2'h2
`endif

// *** i2csf_checker_sva.sv ***
// Port-level checks of the status-flag block
`timescale 1ns/1ps
`include "i2csf_consts.vh"
module i2csf_checker (
    input logic CLOCK,
    input logic RSTN,
    input logic S_AXI_AWVALID,
    input logic S_AXI_AWREADY,
    input logic S_AXI_WVALID,
    input logic S_AXI_WREADY,
    input logic S_AXI_BVALID,
    input logic S_AXI_BREADY,
    input logic [1:0] S_AXI_BRESP,
    input logic [11:0] S_AXI_ARADDR,
    input logic S_AXI_ARVALID,
    input logic S_AXI_ARREADY,
    input logic S_AXI_RVALID,
    input logic S_AXI_RREADY,
    input logic [31:0] S_AXI_RDATA,
    input logic [1:0] S_AXI_RRESP,
    input logic SDA_OE,
    input logic SCL_OE
);
    logic [11:0] ra_reg;
    wire mapped = ra_reg inside {12'h284, 12'h288, 12'h28C, 12'h290, 12'h2A0, 12'h2A4, 12'h2A8};
    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) ra_reg <= 12'h000;
        else if (S_AXI_ARVALID && S_AXI_ARREADY) ra_reg <= S_AXI_ARADDR;
    end
    default clocking dcb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    sequence ar_take; S_AXI_ARVALID && S_AXI_ARREADY; endsequence
    sequence wr_take; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY; endsequence
    a_rd_answer: assert property (ar_take |=> S_AXI_RVALID)
        else $error("read answer late");
    a_wr_answer: assert property (wr_take |-> ##[1:2] S_AXI_BVALID)
        else $error("write answer late");
    a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP))
        else $error("read answer dropped");
    a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write answer dropped");
    a_rsv_zero: assert property (S_AXI_RVALID && ra_reg == 12'h28C |-> !S_AXI_RDATA[3])
        else $error("reserved status bit set");
    a_upper_zero: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
        else $error("upper read bits set");
    a_bad_addr: assert property (S_AXI_RVALID && !mapped |->
        S_AXI_RRESP == `I2CSF_RESP_SLVERR && S_AXI_RDATA == 32'h0)
        else $error("unmapped read accepted");
    a_no_drive: assert property (!SDA_OE && !SCL_OE)
        else $error("bus line driven");
endmodule // i2csf_checker
bind i2csf_top i2csf_checker u_chk (.CLOCK(CLOCK), .RSTN(RSTN),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .SDA_OE(SDA_OE), .SCL_OE(SCL_OE));

// *** i2csf_bus_peer.sv ***
// Behavioural bus master on the two-wire lines, 320 ns bit period
`timescale 1ns/1ps
module i2csf_bus_peer (
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'h1;
        sda = 1'h1;
    end
    task automatic bit_out(input logic v);
        sda = v;
        #80 scl = 1'h1;
        #160 scl = 1'h0;
        #80;
    endtask
    task automatic start_c();
        #13 sda = 1'h0;
        #160 scl = 1'h0;
    endtask
    // START then STOP with no clock pulse in between
    task automatic glitch_c();
        #13 sda = 1'h0;
        #160 sda = 1'h1;
        #160;
    endtask
    task automatic stop_c();
        sda = 1'h0;
        #80 scl = 1'h1;
        #160 sda = 1'h1;
        #160;
    endtask
    // Ninth bit: 1 is released line, 0 is another slave acking
    task automatic send(input logic [7:0] b, input logic ack);
        for (int i = 7; i >= 0; i--) bit_out(b[i]);
        bit_out(ack);
    endtask
endmodule // i2csf_bus_peer

// *** i2csf_bench.sv ***
// Self-checking bench of the status-flag block
`timescale 1ns/1ps
`include "i2csf_consts.vh"
module i2c_status_flag_logic_bench;
    logic clock = 1'h0;
    logic rstn = 1'h0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    wire awready, wready, bvalid, arready, rvalid, irq, ev_irq;
    wire sda_out, sda_oe, scl_out, scl_oe, p_scl, p_sda;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire sda_ln = p_sda & ~(sda_oe & ~sda_out);
    wire scl_ln = p_scl & ~(scl_oe & ~scl_out);
    int mismatches = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic [1:0] rs;
    logic [7:0] own, ab;
    logic hit, ack, rw;
    i2csf_top u_dut (.CLOCK(clock), .RSTN(rstn), .SCL_IN(scl_ln), .SDA_IN(sda_ln),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SCL_OUT(scl_out), .SCL_OE(scl_oe),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .IRQ(irq), .EV_IRQ(ev_irq));
    i2csf_bus_peer u_peer (.scl(p_scl), .sda(p_sda));
    initial forever #20 clock = ~clock;
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic ad = 1'h0;
        logic wd = 1'h0;
        @(posedge clock);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (!(ad && wd)) begin
            @(posedge clock);
            if (awvalid && awready) begin ad = 1'h1; awvalid <= 1'h0; end
            if (wvalid && wready) begin wd = 1'h1; wvalid <= 1'h0; end
        end
        repeat ($urandom_range(2, 0)) @(posedge clock);
        bready <= 1'h1;
        do @(posedge clock); while (!bvalid);
        bready <= 1'h0;
        rs = bresp;
    endtask
    task automatic rdr(input logic [11:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'h1;
        do @(posedge clock); while (!arready);
        arvalid <= 1'h0;
        repeat ($urandom_range(2, 0)) @(posedge clock);
        rready <= 1'h1;
        do @(posedge clock); while (!rvalid);
        rready <= 1'h0;
        rd = rdata;
        rs = rresp;
    endtask
    // Status fields in register order, reserved bit forced to zero
    function automatic logic [7:0] sx(input logic d, m, b, a, r, i, k);
        return {d, m, b, a, 1'h0, r, i, k};
    endfunction
    task automatic st(input string n, input logic [7:0] exp, input logic [7:0] m);
        rdr(`I2CSF_OFF_STATUS);
        chk(n, rd & {24'h000000, m}, {24'h000000, exp & m});
    endtask
    initial begin
        void'($urandom(70));
        repeat (4) @(posedge clock);
        rstn <= 1'h1;
        repeat (2) @(posedge clock);
        st("reset", 8'h81, 8'hFF);
        own = {7'($urandom_range(127, 1)), 1'h0};
        wr(`I2CSF_OFF_OWNADDR, own);
        chk("wr_resp", 32'(rs), 32'(`I2CSF_RESP_OKAY));
        wr(`I2CSF_OFF_CTRL, 8'h80);
        wr(`I2CSF_OFF_IRQ_EN, 8'h02);
        for (int k = 0; k < 6; k++) begin
            hit = (k % 2 == 0);
            rw = 1'($urandom_range(1, 0));
            ack = 1'($urandom_range(1, 0));
            ab = hit ? {own[7:1], rw} : {own[7:1] ^ 7'($urandom_range(127, 1)), rw};
            u_peer.start_c();
            repeat (4) @(posedge clock);
            chk("ev_irq", 32'(ev_irq), 32'h1);
            rdr(`I2CSF_OFF_IRQ_ST);
            chk("ev_start", rd & 32'h2, 32'h2);
            wr(`I2CSF_OFF_IRQ_CLR, 8'h0F);
            repeat (2) @(posedge clock);
            chk("ev_clr", 32'(ev_irq), 32'h0);
            u_peer.send(ab, ack);
            repeat (4) @(posedge clock);
            st("addr", sx(1, hit, 1, 0, rw, 1, ack), hit ? 8'hFF : 8'hFB);
            chk("irq_off", 32'(irq), 32'h0);
            wr(`I2CSF_OFF_CTRL, 8'hC0);
            repeat (2) @(posedge clock);
            chk("irq_on", 32'(irq), 32'h1);
            st("ctrl_wr", sx(1, 0, 1, 0, rw, 1, ack), 8'hFB);
            wr(`I2CSF_OFF_STATUS, 8'h00);
            repeat (2) @(posedge clock);
            chk("irq_clr", 32'(irq), 32'h0);
            rdr(`I2CSF_OFF_DATA);
            st("data_rd", sx(0, 0, 1, 0, rw, 0, ack), 8'hFB);
            u_peer.stop_c();
            repeat (4) @(posedge clock);
            st("stop", sx(0, 0, 0, 0, 0, 0, ack), 8'hE9);
            wr(`I2CSF_OFF_STATUS, 8'h00);
            wr(`I2CSF_OFF_CTRL, 8'h80);
        end
        wr(`I2CSF_OFF_IRQ_EN, 8'h00);
        u_peer.start_c();
        repeat (4) @(posedge clock);
        chk("ev_mask", 32'(ev_irq), 32'h0);
        wr(`I2CSF_OFF_CTRL, 8'hA0);
        st("busy_start", 8'h32, 8'h32);
        rdr(`I2CSF_OFF_CTRL);
        chk("msel", rd & 32'h20, 32'h0);
        wr(`I2CSF_OFF_STATUS, 8'hFF);
        st("ro_write", 8'h32, 8'h3A);
        wr(`I2CSF_OFF_STATUS, 8'h00);
        st("arb_clr", 8'h00, 8'h12);
        u_peer.stop_c();
        repeat (4) @(posedge clock);
        wr(`I2CSF_OFF_STATUS, 8'h00);
        wr(`I2CSF_OFF_CTRL, 8'h84);
        st("rstart", 8'h12, 8'h12);
        wr(`I2CSF_OFF_STATUS, 8'h00);
        wr(`I2CSF_OFF_CTRL, 8'hA0);
        st("idle_start", 8'h00, 8'h10);
        u_peer.glitch_c();
        repeat (4) @(posedge clock);
        st("stop_lost", 8'h12, 8'h32);
        rdr(`I2CSF_OFF_CTRL);
        chk("msel_stop", rd & 32'h20, 32'h0);
        wr(`I2CSF_OFF_STATUS, 8'h00);
        wr(`I2CSF_OFF_CTRL, 8'hA0);
        u_peer.start_c();
        u_peer.bit_out(1'h0);
        repeat (4) @(posedge clock);
        st("sda_lost", 8'h32, 8'h32);
        chk("lines_out", 32'({sda_out, scl_out}), 32'h0);
        u_peer.stop_c();
        repeat (4) @(posedge clock);
        wr(12'h2FC, 8'h00);
        chk("bad_wresp", 32'(rs), 32'(`I2CSF_RESP_SLVERR));
        rdr(12'h2FC);
        chk("bad_resp", 32'(rs), 32'(`I2CSF_RESP_SLVERR));
        chk("bad_data", rd, 32'h0);
        end_of_test();
    end
endmodule // i2c_status_flag_logic_bench
